//--- src/ssr_pkg.sv
/*
  Package for the supply-supervisor reset generator: output variants, timing
  figures and derived cycle counts, reset values and the pin carrier struct.
  Assumes a single 10 MHz core clock.
*/
package ssr_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Recovery period in ms, least time, rounds up
  localparam int unsigned REC_MS = 100;
  localparam int unsigned REC_CYC = (REC_MS * (CLK_HZ / 1000) + 0) == 0 ? 1 : REC_MS * (CLK_HZ / 1000);

  // Manual request hold time in ns, least time, rounds up
  localparam int unsigned MAN_HOLD_NS = 1500;
  localparam int unsigned MAN_HOLD_CYC = (MAN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Supply transient filter window in ns, shortest dip that counts, rounds down
  localparam int unsigned GLITCH_NS = 20_000;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS / CLK_PERIOD_NS;

  localparam logic RESET_ASSERTED = 1'b1;

  typedef enum logic [1:0] {
    SSR_LOW_PP    = 2'h0,
    SSR_LOW_OD    = 2'h1,
    SSR_HIGH_PP   = 2'h2,
    SSR_LOW_OD_MR = 2'h3
  } ssr_variant_e;

  typedef struct packed {
    logic o;
    logic oe;
  } ssr_pin_s;

endpackage

//--- src/ssr_filter.sv
/*
  Level filter: the output follows the input only after the input has held a
  new level for HOLD consecutive cycles.
  Assumes the input is already synchronised to clk.
*/
`timescale 1ns/1ps
module ssr_filter #(
  parameter int unsigned HOLD = 2,
  parameter logic INIT = 1'b0
) (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic din, // Synchronised level
  output logic dout // Filtered level
);

  localparam int unsigned CW = $clog2(HOLD + 1);

  logic [CW-1:0] cnt_r;
  logic dout_r;
  wire differ = din != dout_r;
  wire done = cnt_r >= CW'(HOLD - 1);

  initial begin
    if (HOLD < 1) $error("ssr_filter: HOLD must be at least 1");
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      dout_r <= INIT;
    end else if (!differ) begin
      cnt_r <= '0;
    end else if (done) begin
      cnt_r <= '0;
      dout_r <= din;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign dout = dout_r;

endmodule

//--- src/ssr_reset_gen.sv
/*
  Supply-supervisor reset generator: filters the undervoltage indication,
  optionally senses manual pull-downs on the shared reset pin, and holds the
  reset output for the recovery period.
  Assumes undervoltage comes asynchronously from a comparator and the pad
  resolves the pin from o/oe with a weak pull-up for open-drain variants.
*/
`timescale 1ns/1ps
module ssr_reset_gen
  import ssr_pkg::*;
#(
  parameter ssr_variant_e VARIANT = SSR_LOW_OD_MR,
  parameter int unsigned REC_CYCLES = REC_CYC,
  parameter int unsigned MAN_CYCLES = MAN_HOLD_CYC,
  parameter int unsigned FILT_CYCLES = GLITCH_CYC
) (
  input wire logic mclk, // Free-running internal clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic undervolt, // Comparator: supply below threshold
  input wire logic pin_i, // Sensed level of the reset pin
  output logic pin_o, // Reset pin drive value
  output logic pin_oe, // Reset pin drive enable
  output logic reset_active // Internal reset state, high while asserted
);

  localparam int unsigned RW = $clog2(REC_CYCLES + 1);
  localparam logic IS_OD = (VARIANT == SSR_LOW_OD) || (VARIANT == SSR_LOW_OD_MR);
  localparam logic HAS_MR = VARIANT == SSR_LOW_OD_MR;

  initial begin
    if (REC_CYCLES < 1 || MAN_CYCLES < 1 || FILT_CYCLES < 1) $error("ssr_reset_gen: counts must be at least 1");
  end

  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_RECOVER = 3'h2,
    ST_RUN = 3'h4
  } ssr_state_e;

  // Two-stage synchronisers for asynchronous inputs
  logic [1:0] uv_sync_r;
  logic [1:0] pin_sync_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uv_sync_r <= 2'h3;
      pin_sync_r <= 2'h3;
    end else begin
      uv_sync_r <= {uv_sync_r[0], undervolt};
      pin_sync_r <= {pin_sync_r[0], pin_i};
    end
  end

  // Supply dips must persist for the filter window to count
  logic uv_filt;
  ssr_filter #(.HOLD(FILT_CYCLES), .INIT(1'b1)) u_uv_filt (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(uv_sync_r[1]),
    .dout(uv_filt)
  );

  logic pin_oe_r;
  logic pin_o_r;
  logic reset_r;
  logic [1:0] oe_hist_r;
  logic mr_filt;
  logic [RW-1:0] rec_cnt_r;
  ssr_state_e state_r;
  ssr_state_e state_nxt;

  // Pin low while we have not driven it for the last sync span is an outside pull
  wire ext_low_raw = HAS_MR && !pin_sync_r[1] && !pin_oe_r && (oe_hist_r == 2'h0);

  // Debounce: a pull counts only after MAN_CYCLES of steady low; shorter pulses are lost
  ssr_filter #(.HOLD(MAN_CYCLES), .INIT(1'b0)) u_mr_deb (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(ext_low_raw),
    .dout(mr_filt)
  );

  // The line is left to the outside pull while it lasts so that its release is seen;
  // the line reads high for the sync span before our own drive takes over
  wire man_hold = mr_filt && ext_low_raw;
  wire hold_req = uv_filt || man_hold;
  wire rec_done = rec_cnt_r >= RW'(REC_CYCLES - 1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_HOLD: begin
        if (!hold_req) state_nxt = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (hold_req) state_nxt = ST_HOLD;
        else if (rec_done) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (hold_req) state_nxt = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HOLD;
      rec_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      rec_cnt_r <= (state_r == ST_RECOVER && !hold_req) ? rec_cnt_r + RW'(1) : '0;
    end
  end

  // Output drive per variant
  wire assert_nxt = state_nxt != ST_RUN;
  wire o_nxt = (VARIANT == SSR_HIGH_PP) ? assert_nxt : !assert_nxt;
  wire oe_nxt = IS_OD ? (assert_nxt && !man_hold) : 1'b1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_r <= RESET_ASSERTED;
      pin_o_r <= (VARIANT == SSR_HIGH_PP) ? 1'b1 : 1'b0;
      pin_oe_r <= 1'b1;
      oe_hist_r <= 2'h3;
    end else begin
      reset_r <= assert_nxt;
      pin_o_r <= o_nxt;
      pin_oe_r <= oe_nxt;
      oe_hist_r <= {oe_hist_r[0], pin_oe_r};
    end
  end

  assign pin_o = pin_o_r;
  assign pin_oe = pin_oe_r;
  assign reset_active = reset_r;

endmodule

//--- verif/ssr_monitor.sv
/* Port checker for the reset generator.
   Assumes one clock and rst_n as its reset. */
`timescale 1ns/1ps
module ssr_monitor
  import ssr_pkg::*;
#(
  parameter ssr_variant_e VARIANT = SSR_LOW_OD_MR,
  parameter int unsigned REC_CYCLES = 50
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic undervolt, // Supply low
  input wire logic pin_i, // Line level
  input wire logic pin_o, // Drive value
  input wire logic pin_oe, // Drive enable
  input wire logic reset_active // Reset state
);
  localparam logic IS_OD = (VARIANT == SSR_LOW_OD) || (VARIANT == SSR_LOW_OD_MR);
  int unsigned good_r;
  // Cycles since supply or an outside pull last asked for reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) good_r <= 0;
    else if (undervolt || (!pin_i && !pin_oe)) good_r <= 0;
    else if (good_r < 9999) good_r <= good_r + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_uv_hold; $rose(undervolt) ##1 undervolt [*8]; endsequence
  sequence s_blip; !reset_active ##1 $rose(undervolt) ##1 undervolt ##1 !undervolt; endsequence
  sequence s_press; (VARIANT == SSR_LOW_OD_MR && !pin_i && !pin_oe) [*8]; endsequence
  property p_uv; s_uv_hold |-> ##[0:4] reset_active; endproperty
  property p_glitch; s_blip |-> !reset_active [*6]; endproperty
  property p_hold; $fell(reset_active) |-> good_r >= REC_CYCLES; endproperty
  property p_release; good_r == REC_CYCLES + 20 |-> !reset_active; endproperty
  property p_pol; VARIANT == SSR_HIGH_PP ? pin_o == reset_active : (!reset_active || !pin_o); endproperty
  property p_drive;
    IS_OD ? (pin_oe ? reset_active : (!reset_active || (VARIANT == SSR_LOW_OD_MR && good_r < 8))) : pin_oe;
  endproperty
  property p_man; s_press |-> ##[0:6] reset_active; endproperty
  property p_short; ($fell(pin_i) && !pin_oe && !reset_active) ##1 pin_i |-> !reset_active [*6]; endproperty
  a_uv: assert property (p_uv) else $error("no reset on undervoltage");
  a_glitch: assert property (p_glitch) else $error("reset on short dip");
  a_hold: assert property (p_hold) else $error("released early");
  a_release: assert property (p_release) else $error("held too long");
  a_pol: assert property (p_pol) else $error("wrong polarity");
  a_drive: assert property (p_drive) else $error("wrong drive enable");
  a_man: assert property (p_man) else $error("manual hold ignored");
  a_short: assert property (p_short) else $error("short pull gave reset");
endmodule

//--- verif/ssr_partner.sv
/* Reset line: microcontroller input, pull-up and push button.
   Assumes the bench drives the button. */
`timescale 1ns/1ps
module ssr_partner (
  input wire logic pin_o, // Device drive value
  input wire logic pin_oe, // Device drive enable
  input wire logic press, // Button held
  output logic pin_i, // Line level
  output logic mcu_rst // Microcontroller in reset
);
  // Button shorts to ground; a released line floats up
  assign pin_i = press ? 1'b0 : (pin_oe ? pin_o : 1'b1);
  assign mcu_rst = !pin_i;
endmodule

//--- verif/ssr_reset_gen_tb_top.sv
/* Bench: manual-detect and active-high instances with a button model.
   Assumes short build counts. */
`timescale 1ns/1ps
module ssr_reset_gen_tb_top;
  import ssr_pkg::*;
  localparam int unsigned REC = 50;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic uv = 1'b0;
  logic press = 1'b0;
  logic pin_i, pin_o, pin_oe, act, hp_o, hp_oe, hp_act, mcu_rst;
  int error_cnt = 0;
  int n_checks = 0;
  always #50 mclk = ~mclk;
  ssr_reset_gen #(.VARIANT(SSR_LOW_OD_MR), .REC_CYCLES(REC), .MAN_CYCLES(3), .FILT_CYCLES(4)) i_ssr_reset_gen (
    .mclk(mclk), .rst_n(rst_n), .undervolt(uv), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .reset_active(act));
  ssr_reset_gen #(.VARIANT(SSR_HIGH_PP), .REC_CYCLES(REC), .MAN_CYCLES(3), .FILT_CYCLES(4)) i_ssr_reset_gen_hp (
    .mclk(mclk), .rst_n(rst_n), .undervolt(uv), .pin_i(1'b1), .pin_o(hp_o), .pin_oe(hp_oe), .reset_active(hp_act));
  ssr_partner i_ssr_partner (.pin_o(pin_o), .pin_oe(pin_oe), .press(press), .pin_i(pin_i), .mcu_rst(mcu_rst));
  task chk(input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Samples away from the clock edge
  task look(input logic ea, input logic eh);
    @(negedge mclk);
    chk(ea, mcu_rst);
    chk(ea, act);
    chk(eh, hp_o);
    chk(eh, hp_act);
    chk(1'b1, hp_oe);
  endtask
  task t_por;
    cyc(REC / 2);
    look(1'b1, 1'b1);
    cyc(REC);
    look(1'b0, 1'b0);
    $display("power-up done");
  endtask
  task t_uv;
    @(posedge mclk) uv <= 1'b1;
    cyc(12);
    look(1'b1, 1'b1);
    @(posedge mclk) uv <= 1'b0;
    cyc(REC / 2);
    uv <= 1'b1;
    cyc(12);
    uv <= 1'b0;
    cyc(REC - 10);
    look(1'b1, 1'b1);
    cyc(40);
    look(1'b0, 1'b0);
    $display("undervoltage done");
  endtask
  task t_glitch;
    @(posedge mclk) uv <= 1'b1;
    cyc(2);
    uv <= 1'b0;
    cyc(10);
    look(1'b0, 1'b0);
    $display("glitch done");
  endtask
  task t_man;
    repeat (3) begin
      @(posedge mclk) press <= 1'b1;
      @(posedge mclk) press <= 1'b0;
    end
    cyc(10);
    look(1'b0, 1'b0);
    @(posedge mclk) press <= 1'b1;
    cyc(12);
    look(1'b1, 1'b0);
    @(posedge mclk) press <= 1'b0;
    cyc(REC / 2);
    look(1'b1, 1'b0);
    cyc(REC + 20);
    look(1'b0, 1'b0);
    $display("manual done");
  endtask
  task complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    t_por;
    t_uv;
    t_glitch;
    t_man;
    complete_run;
  end
  initial begin
    cyc(2000);
    error_cnt++;
    complete_run;
  end
endmodule
bind ssr_reset_gen ssr_monitor #(.VARIANT(VARIANT), .REC_CYCLES(REC_CYCLES)) i_ssr_monitor (.mclk(mclk),
  .rst_n(rst_n), .undervolt(undervolt), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .reset_active(reset_active));
